// ===== shared/dscd_pkg.sv
package dscd_pkg;

	// Frame geometry.
	localparam int FRAME_BITS = 24;
	localparam int FRAME_CNT_W = 5;
	localparam int RW_POS = 23;
	localparam int ZERO_POS = 22;
	localparam int SEL_HI = 21;
	localparam int SEL_LO = 19;
	localparam int CHAN_HI = 18;
	localparam int CHAN_LO = 16;
	localparam int DATA_W = 16;
	localparam int NUM_CHAN = 2;

	// Target select codes.
	localparam logic [2:0] SEL_FUNC = 3'h0;
	localparam logic [2:0] SEL_DATA = 3'h2;
	localparam logic [2:0] SEL_COARSE = 3'h3;
	localparam logic [2:0] SEL_FINE = 3'h4;
	localparam logic [2:0] SEL_OFFSET = 3'h5;

	// Channel select codes, and function selectors that share the same field.
	localparam logic [2:0] CHAN_A = 3'h0;
	localparam logic [2:0] CHAN_B = 3'h1;
	localparam logic [2:0] CHAN_BOTH = 3'h4;
	localparam logic [2:0] FN_NOP = 3'h0;
	localparam logic [2:0] FN_CTRL = 3'h1;
	localparam logic [2:0] FN_CLEAR = 3'h4;
	localparam logic [2:0] FN_LOAD = 3'h5;

	// Control word field positions.
	localparam int CW_SDO_DIS = 0;
	localparam int CW_IO0_VAL = 1;
	localparam int CW_IO0_DIR = 2;
	localparam int CW_IO1_VAL = 3;
	localparam int CW_IO1_DIR = 4;
	localparam int CW_LGO_EN = 5;
	localparam int CW_W = 6;
	localparam logic [5:0] CW_RESET = 6'h00;

	// Register widths and reset values.
	localparam int COARSE_W = 2;
	localparam int FINE_W = 6;
	localparam int OFFSET_W = 8;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [15:0] CLEAR_TWOS = 16'h0000;
	localparam logic [15:0] CLEAR_BIN = 16'h0000;

	// One decoded frame handed from the link domain to the core.
	typedef struct packed {
		logic rd;
		logic [2:0] sel;
		logic [2:0] chan;
		logic [15:0] data;
		logic load_strobe_n_low;
	} dscd_frame_t;

	// Per-channel programmed registers.
	typedef struct packed {
		logic [15:0] input_code;
		logic [15:0] dac_code;
		logic [1:0] coarse;
		logic [5:0] fine;
		logic [7:0] offset;
	} dscd_chan_t;

endpackage : dscd_pkg

// ===== hdl/dscd_shifter.sv
`timescale 1ns/1ps
// Link-side shift register: runs on the serial clock, counts falling edges
// while frame sync is low, and shifts readback data out on rising edges.
module dscd_shifter #(
	parameter int FRAME_BITS = dscd_pkg::FRAME_BITS
) (
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic sdin,
	input wire logic load_strobe_n_n,
	input wire logic [FRAME_BITS-1:0] rd_word,
	output logic [FRAME_BITS-1:0] frame_word,
	output logic frame_ok,
	output logic frame_load_strobe_n_low,
	output logic sdo_bit
);
	// Shift register, fills MSB first.
	logic [FRAME_BITS-1:0] shift_ff;
	logic [FRAME_BITS-1:0] nxt_shift;
	// Saturating count of falling edges within the frame.
	logic [dscd_pkg::FRAME_CNT_W-1:0] cnt_ff;
	logic [dscd_pkg::FRAME_CNT_W-1:0] nxt_cnt;
	// Sampled load strobe level during the shift.
	logic load_strobe_n_ff;
	logic nxt_load_strobe_n;
	// Set when the last falling edge was exactly the frame's last; it stands while sync is high.
	logic ok_ff;
	logic nxt_ok;
	// Output shift register holding readback word.
	logic [FRAME_BITS-1:0] out_ff;
	logic [FRAME_BITS-1:0] nxt_out;

	// The edge count must reach one past a full frame without wrapping.
	if (FRAME_BITS < 2 || FRAME_BITS >= (1 << dscd_pkg::FRAME_CNT_W) - 1) begin : g_bad_len
		$error("Frame length does not fit the edge counter.");
	end

	// Next values for the falling edge process.
	always_comb begin
		nxt_shift = {shift_ff[FRAME_BITS-2:0], sdin};
		nxt_cnt = cnt_ff;
		nxt_load_strobe_n = load_strobe_n_ff & ~load_strobe_n_n;
		// First edge of a frame restarts the load strobe sample; the count was already cleared while sync was high.
		if (cnt_ff == '0) begin
			nxt_load_strobe_n = ~load_strobe_n_n;
		end
		if (cnt_ff != '1) begin
			nxt_cnt = cnt_ff + 1'b1;
		end
		// Only the edge that completes the frame length marks it good.
		nxt_ok = (nxt_cnt == dscd_pkg::FRAME_CNT_W'(FRAME_BITS));
	end

	// Falling edge capture; the count is reset while frame sync is high.
	always_ff @(negedge sclk or posedge sync_n) begin
		if (sync_n) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
			shift_ff <= nxt_shift;
			load_strobe_n_ff <= nxt_load_strobe_n;
			ok_ff <= nxt_ok;
		end
	end

	// Next value for readback output: the frame's first rising edge, after one fall, reloads.
	// The MSB itself is shown straight from the word before that edge.
	always_comb begin
		nxt_out = {out_ff[FRAME_BITS-2:0], 1'b0};
		if (cnt_ff == dscd_pkg::FRAME_CNT_W'(1'b1)) begin
			nxt_out = {rd_word[FRAME_BITS-2:0], 1'b0};
		end
	end

	// Rising edge shifting of readback data; the MSB is presented at frame start.
	always_ff @(posedge sclk) begin
		out_ff <= nxt_out;
	end

	// Frame is valid only with exactly the frame length of falling edges.
	assign frame_ok = ok_ff;
	assign frame_word = shift_ff;
	assign frame_load_strobe_n_low = load_strobe_n_ff;
	assign sdo_bit = (cnt_ff == '0) ? rd_word[FRAME_BITS-1] : out_ff[FRAME_BITS-1];
endmodule : dscd_shifter

// ===== hdl/dscd_core.sv
`timescale 1ns/1ps
module dscd_core #(
	parameter int NUM_CHAN = dscd_pkg::NUM_CHAN
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CE,
	input wire logic SCLK,
	input wire logic SYNC_N,
	input wire logic SDIN,
	input wire logic LOAD_STROBE_N,
	input wire logic ASYNC_WIPE_N,
	input wire logic CODING_SELECT,
	input wire logic IO_PIN_FIRST_I,
	input wire logic IO_PIN_SECOND_I,
	output logic IO_PIN_FIRST_O,
	output logic IO_PIN_FIRST_OE,
	output logic IO_PIN_SECOND_O,
	output logic IO_PIN_SECOND_OE,
	output logic SERIAL_OUT,
	output logic SERIAL_OUT_OE,
	output logic LGO_ENABLE,
	output logic [dscd_pkg::DATA_W*NUM_CHAN-1:0] DAC_CODE,
	output logic [dscd_pkg::COARSE_W*NUM_CHAN-1:0] COARSE_GAIN,
	output logic [dscd_pkg::FINE_W*NUM_CHAN-1:0] FINE_GAIN,
	output logic [dscd_pkg::OFFSET_W*NUM_CHAN-1:0] OFFSET_ADJ
);
	localparam int FB = dscd_pkg::FRAME_BITS;

	// The channel decode only knows two channels.
	if (NUM_CHAN != 2) begin : g_bad_chan
		$error("Channel decode serves exactly two channels.");
	end

	// Link-domain frame and readback wiring.
	logic [FB-1:0] lk_word;
	logic lk_ok;
	logic lk_load_strobe_n;
	logic lk_sdo;
	// Readback bit crossing into the system clock; stage one feeds only the output flop.
	logic sdo_s1_ff;
	logic [FB-1:0] rd_word_ff;
	logic [FB-1:0] nxt_rd_word;

	dscd_shifter #(.FRAME_BITS(FB)) u_shift (
		.sclk(SCLK),
		.sync_n(SYNC_N),
		.sdin(SDIN),
		.load_strobe_n_n(LOAD_STROBE_N),
		.rd_word(rd_word_ff),
		.frame_word(lk_word),
		.frame_ok(lk_ok),
		.frame_load_strobe_n_low(lk_load_strobe_n),
		.sdo_bit(lk_sdo)
	);

	// Pin synchronisers; stage one is read only by stage two.
	logic [5:0] s1_ff;
	logic [5:0] s2_ff;
	logic sync_prev_ff;
	logic wipe_prev_ff;
	logic load_strobe_n_prev_ff;
	logic ok_s1_ff;
	logic ok_s2_ff;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			s1_ff <= 6'h3F;
			s2_ff <= 6'h3F;
			ok_s1_ff <= 1'b0;
			ok_s2_ff <= 1'b0;
		end else if (CE) begin
			s1_ff <= {SYNC_N, ASYNC_WIPE_N, LOAD_STROBE_N, CODING_SELECT,
				IO_PIN_FIRST_I, IO_PIN_SECOND_I};
			s2_ff <= s1_ff;
			ok_s1_ff <= lk_ok;
			ok_s2_ff <= ok_s1_ff;
		end
	end
	wire sync_s = s2_ff[5];
	wire wipe_s = s2_ff[4];
	wire load_strobe_n_s = s2_ff[3];
	wire coding_s = s2_ff[2];
	wire pin0_s = s2_ff[1];
	wire pin1_s = s2_ff[0];

	// Edge detectors on synchronised pins.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sync_prev_ff <= 1'b1;
			wipe_prev_ff <= 1'b1;
			load_strobe_n_prev_ff <= 1'b1;
		end else if (CE) begin
			sync_prev_ff <= sync_s;
			wipe_prev_ff <= wipe_s;
			load_strobe_n_prev_ff <= load_strobe_n_s;
		end
	end
	// The shifter's word is stable while sync is high, so it is sampled here.
	wire frame_take = sync_s & ~sync_prev_ff & ok_s2_ff;
	wire wipe_fall = ~wipe_s & wipe_prev_ff;
	wire load_strobe_n_fall = ~load_strobe_n_s & load_strobe_n_prev_ff;

	// Frame fields split out.
	dscd_pkg::dscd_frame_t fr;
	assign fr.rd = lk_word[dscd_pkg::RW_POS];
	assign fr.sel = lk_word[dscd_pkg::SEL_HI:dscd_pkg::SEL_LO];
	assign fr.chan = lk_word[dscd_pkg::CHAN_HI:dscd_pkg::CHAN_LO];
	assign fr.data = lk_word[dscd_pkg::DATA_W-1:0];
	assign fr.load_strobe_n_low = lk_load_strobe_n;
	wire zero_ok = ~lk_word[dscd_pkg::ZERO_POS];

	// Register state.
	dscd_pkg::dscd_chan_t ch_ff [NUM_CHAN];
	dscd_pkg::dscd_chan_t nxt_ch [NUM_CHAN];
	logic [dscd_pkg::CW_W-1:0] cw_ff;
	logic [dscd_pkg::CW_W-1:0] nxt_cw;
	logic pwr_ff;
	logic nxt_pwr;
	// Power-on check window, open for one cycle from the third enabled clock after reset release.
	logic pwr_arm_ff;
	logic [1:0] arm_cnt_ff;

	// Decoding flags of the taken frame.
	logic is_func;
	logic chan_ok;
	logic sel_ok;
	logic do_clear;
	logic do_load;
	logic [15:0] clear_val;
	logic [15:0] rd_val;
	logic [NUM_CHAN-1:0] hit;

	// Frame decode, register writes, clear and load.
	always_comb begin
		nxt_ch = ch_ff;
		nxt_cw = cw_ff;
		nxt_pwr = ~wipe_s & ~wipe_prev_ff & pwr_arm_ff;
		nxt_rd_word = rd_word_ff;
		rd_val = '0;
		// Clear value follows the coding.
		clear_val = coding_s ? dscd_pkg::CLEAR_BIN : dscd_pkg::CLEAR_TWOS;
		is_func = (fr.sel == dscd_pkg::SEL_FUNC);
		sel_ok = is_func || (fr.sel == dscd_pkg::SEL_DATA) || (fr.sel == dscd_pkg::SEL_COARSE)
			|| (fr.sel == dscd_pkg::SEL_FINE) || (fr.sel == dscd_pkg::SEL_OFFSET);
		chan_ok = (fr.chan == dscd_pkg::CHAN_A) || (fr.chan == dscd_pkg::CHAN_B)
			|| (fr.chan == dscd_pkg::CHAN_BOTH);
		hit[0] = (fr.chan == dscd_pkg::CHAN_A) || (fr.chan == dscd_pkg::CHAN_BOTH);
		hit[1] = (fr.chan == dscd_pkg::CHAN_B) || (fr.chan == dscd_pkg::CHAN_BOTH);
		do_clear = wipe_fall || pwr_ff;
		do_load = load_strobe_n_fall;
		if (frame_take && zero_ok && sel_ok) begin
			if (fr.rd) begin
				// Readback word for the next frame.
				case (fr.sel)
					dscd_pkg::SEL_FUNC: rd_val = {10'h000, cw_ff};
					dscd_pkg::SEL_DATA: rd_val = ch_ff[fr.chan[0]].input_code;
					dscd_pkg::SEL_COARSE: rd_val = {14'h0000, ch_ff[fr.chan[0]].coarse};
					dscd_pkg::SEL_FINE: rd_val = {10'h000, ch_ff[fr.chan[0]].fine};
					default: rd_val = {8'h00, ch_ff[fr.chan[0]].offset};
				endcase
				// Pins set as inputs report their level instead of the stored bit.
				if (is_func && !cw_ff[dscd_pkg::CW_IO0_DIR]) begin
					rd_val[dscd_pkg::CW_IO0_VAL] = pin0_s;
				end
				if (is_func && !cw_ff[dscd_pkg::CW_IO1_DIR]) begin
					rd_val[dscd_pkg::CW_IO1_VAL] = pin1_s;
				end
				nxt_rd_word = {lk_word[FB-1:dscd_pkg::DATA_W], rd_val};
			end else if (is_func) begin
				case (fr.chan)
					dscd_pkg::FN_NOP: nxt_cw = cw_ff;
					dscd_pkg::FN_CTRL: begin
						// Control word write; pin values only kept for outputs.
						nxt_cw = fr.data[dscd_pkg::CW_W-1:0];
						if (!fr.data[dscd_pkg::CW_IO0_DIR]) begin
							nxt_cw[dscd_pkg::CW_IO0_VAL] = cw_ff[dscd_pkg::CW_IO0_VAL];
						end
						if (!fr.data[dscd_pkg::CW_IO1_DIR]) begin
							nxt_cw[dscd_pkg::CW_IO1_VAL] = cw_ff[dscd_pkg::CW_IO1_VAL];
						end
					end
					dscd_pkg::FN_CLEAR: do_clear = 1'b1;
					dscd_pkg::FN_LOAD: do_load = 1'b1;
					default: nxt_cw = cw_ff;
				endcase
			end else if (chan_ok) begin
				for (int i = 0; i < NUM_CHAN; i++) begin
					if (hit[i]) begin
						case (fr.sel)
							dscd_pkg::SEL_DATA: begin
								nxt_ch[i].input_code = fr.data;
								// Individual update when the strobe was low.
								if (fr.load_strobe_n_low) begin
									nxt_ch[i].dac_code = fr.data;
								end
							end
							dscd_pkg::SEL_COARSE: nxt_ch[i].coarse = fr.data[1:0];
							dscd_pkg::SEL_FINE: nxt_ch[i].fine = fr.data[5:0];
							default: nxt_ch[i].offset = fr.data[7:0];
						endcase
					end
				end
			end
		end
		for (int i = 0; i < NUM_CHAN; i++) begin
			if (do_load) begin
				nxt_ch[i].dac_code = nxt_ch[i].input_code;
			end
			// Clear wins and holds until a new value is written.
			if (do_clear) begin
				nxt_ch[i].input_code = clear_val;
				nxt_ch[i].dac_code = clear_val;
			end
		end
	end

	// Register process; power-on clear is taken on the fifth enabled clock after reset release.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				ch_ff[i] <= '0;
			end
			cw_ff <= dscd_pkg::CW_RESET;
			pwr_ff <= 1'b0;
			rd_word_ff <= '0;
		end else if (CE) begin
			ch_ff <= nxt_ch;
			cw_ff <= nxt_cw;
			pwr_ff <= nxt_pwr;
			rd_word_ff <= nxt_rd_word;
		end
	end

	// Arms the power-on check once after reset release.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			arm_cnt_ff <= 2'h0;
			pwr_arm_ff <= 1'b0;
		end else if (CE) begin
			arm_cnt_ff <= (arm_cnt_ff == 2'h3) ? arm_cnt_ff : arm_cnt_ff + 2'h1;
			pwr_arm_ff <= (arm_cnt_ff == 2'h2);
		end
	end

	// Output registers.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			IO_PIN_FIRST_O <= 1'b0;
			IO_PIN_FIRST_OE <= 1'b0;
			IO_PIN_SECOND_O <= 1'b0;
			IO_PIN_SECOND_OE <= 1'b0;
			SERIAL_OUT_OE <= 1'b0;
			sdo_s1_ff <= 1'b0;
			SERIAL_OUT <= 1'b0;
			LGO_ENABLE <= 1'b0;
			DAC_CODE <= '0;
			COARSE_GAIN <= '0;
			FINE_GAIN <= '0;
			OFFSET_ADJ <= '0;
		end else if (CE) begin
			IO_PIN_FIRST_O <= cw_ff[dscd_pkg::CW_IO0_VAL];
			IO_PIN_FIRST_OE <= cw_ff[dscd_pkg::CW_IO0_DIR];
			IO_PIN_SECOND_O <= cw_ff[dscd_pkg::CW_IO1_VAL];
			IO_PIN_SECOND_OE <= cw_ff[dscd_pkg::CW_IO1_DIR];
			SERIAL_OUT_OE <= ~cw_ff[dscd_pkg::CW_SDO_DIS] & ~sync_s;
			// Two stages keep the link-side bit from reaching the pin half-settled.
			sdo_s1_ff <= lk_sdo;
			SERIAL_OUT <= sdo_s1_ff;
			LGO_ENABLE <= cw_ff[dscd_pkg::CW_LGO_EN];
			for (int i = 0; i < NUM_CHAN; i++) begin
				DAC_CODE[i*dscd_pkg::DATA_W +: dscd_pkg::DATA_W] <= ch_ff[i].dac_code;
				COARSE_GAIN[i*dscd_pkg::COARSE_W +: dscd_pkg::COARSE_W] <= ch_ff[i].coarse;
				FINE_GAIN[i*dscd_pkg::FINE_W +: dscd_pkg::FINE_W] <= ch_ff[i].fine;
				OFFSET_ADJ[i*dscd_pkg::OFFSET_W +: dscd_pkg::OFFSET_W] <= ch_ff[i].offset;
			end
		end
	end

	chk_clear_val: assert property (@(posedge CLK) disable iff (SYS_RST)
		(CE && wipe_fall) |=> (ch_ff[0].dac_code == $past(clear_val)))
		else $error("Clear did not reach channel A.");
	chk_ctrl_lgo: assert property (@(posedge CLK) disable iff (SYS_RST)
		CE |=> ##1 (LGO_ENABLE == $past(cw_ff[dscd_pkg::CW_LGO_EN]) || !$past(CE)))
		else $error("Ground offset enable does not follow the control word.");
	chk_pin_dir: assert property (@(posedge CLK) disable iff (SYS_RST)
		$rose(IO_PIN_FIRST_OE) |-> $past(cw_ff[dscd_pkg::CW_IO0_DIR]))
		else $error("First pin enabled without direction bit.");
	chk_sdo_dis: assert property (@(posedge CLK) disable iff (SYS_RST)
		SERIAL_OUT_OE |-> !$past(cw_ff[dscd_pkg::CW_SDO_DIS]))
		else $error("Serial out driven while disabled.");
	chk_bad_sel: assert property (@(posedge CLK) disable iff (SYS_RST)
		(CE && frame_take && !sel_ok && !do_clear && !do_load) |=> $stable(cw_ff))
		else $error("Unassigned frame changed the control word.");
	chk_soft_load: assert property (@(posedge CLK) disable iff (SYS_RST)
		(CE && do_load && !do_clear) |=> (ch_ff[1].dac_code == ch_ff[1].input_code))
		else $error("Load did not transfer channel B.");
	chk_hold_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
		(CE && do_clear) |=> (ch_ff[0].input_code == ch_ff[0].dac_code))
		else $error("Cleared channel input and output differ.");
	chk_read_word: assert property (@(posedge CLK) disable iff (SYS_RST)
		(CE && frame_take && zero_ok && !fr.rd) |=> $stable(rd_word_ff))
		else $error("Write frame altered the readback word.");
	cov_write: cover property (@(posedge CLK) frame_take && !fr.rd && !is_func);
	cov_read: cover property (@(posedge CLK) frame_take && fr.rd);
	cov_clear: cover property (@(posedge CLK) do_clear);
	cov_load: cover property (@(posedge CLK) load_strobe_n_fall);
endmodule : dscd_core

// ===== tb/dscd_host.sv
`timescale 1ns/1ps
// Serial host model: sends frames MSB first and captures the readback stream.
module dscd_host (
	output logic SCLK,
	output logic SYNC_N,
	output logic SDIN,
	input wire logic SERIAL_OUT,
	input wire logic SERIAL_OUT_OE
);
	// Last captured readback word.
	logic [23:0] rb_word;
	// Set when the readback driver was enabled during the last frame.
	logic oe_seen;

	// The clock idles high and the frame sync idles high outside frames.
	initial begin
		SCLK = 1'b1;
		SYNC_N = 1'b0;
		SDIN = 1'b0;
		rb_word = 24'h000000;
		oe_seen = 1'b0;
		// A short low pulse with no clock edge gives the link counter a clean start.
		#1;
		SYNC_N = 1'b1;
	end

	// Sends n bits of w; any bit past the 24th is filler that spoils the frame.
	task automatic xfer(input logic [23:0] w, input int n);
		int i;
		oe_seen = 1'b0;
		#37;
		SYNC_N = 1'b0;
		for (i = 0; i < n; i++) begin
			SDIN = (i < 24) ? w[23-i] : ~SDIN;
			#80;
			rb_word = {rb_word[22:0], SERIAL_OUT};
			oe_seen = oe_seen | SERIAL_OUT_OE;
			SCLK = 1'b0;
			#80;
			SCLK = 1'b1;
		end
		#80;
		SYNC_N = 1'b1;
		// The released data line shows the inverse, not a stale bit.
		SDIN = ~SDIN;
	endtask : xfer
endmodule : dscd_host

// ===== tb/dac_serial_command_decoder_tb.sv
`timescale 1ns/1ps
// Self-checking bench: notes expected output changes, a watcher compares them.
module dac_serial_command_decoder_tb;
	logic CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic LOAD_STROBE_N = 1'b1;
	logic ASYNC_WIPE_N = 1'b1;
	logic CODING_SELECT = 1'b0;
	logic ext_first = 1'b0;
	logic ext_second = 1'b0;
	logic SCLK, SYNC_N, SDIN, SERIAL_OUT, SERIAL_OUT_OE, LGO_ENABLE;
	logic IO_PIN_FIRST_O, IO_PIN_FIRST_OE, IO_PIN_SECOND_O, IO_PIN_SECOND_OE;
	logic [31:0] DAC_CODE;
	logic [3:0] COARSE_GAIN;
	logic [11:0] FINE_GAIN;
	logic [15:0] OFFSET_ADJ;
	// Pin levels resolve from the device drive and the outside world.
	wire logic io_first = IO_PIN_FIRST_OE ? IO_PIN_FIRST_O : ext_first;
	wire logic io_second = IO_PIN_SECOND_OE ? IO_PIN_SECOND_O : ext_second;
	// All per-channel register outputs as one vector.
	wire logic [63:0] obs = {DAC_CODE, COARSE_GAIN, FINE_GAIN, OFFSET_ADJ};
	logic [63:0] cur = 64'h0;
	logic [63:0] last_seen = 64'h0;
	logic [63:0] exp_q[$];
	logic [15:0] in_code [2] = '{16'h0000, 16'h0000};
	logic [2:0] chans [3] = '{dscd_pkg::CHAN_A, dscd_pkg::CHAN_B, dscd_pkg::CHAN_BOTH};
	logic [31:0] rng = 32'h00000024;
	logic [15:0] v;
	int fails = 0;
	int compares = 0;
	int i;
	int s;

	// System clock, 8 ns period.
	always #4 CLK = ~CLK;

	dscd_core u_dut (.CLK(CLK), .SYS_RST(SYS_RST), .CE(1'b1), .SCLK(SCLK), .SYNC_N(SYNC_N),
		.SDIN(SDIN), .LOAD_STROBE_N(LOAD_STROBE_N), .ASYNC_WIPE_N(ASYNC_WIPE_N),
		.CODING_SELECT(CODING_SELECT), .IO_PIN_FIRST_I(io_first), .IO_PIN_SECOND_I(io_second),
		.IO_PIN_FIRST_O(IO_PIN_FIRST_O), .IO_PIN_FIRST_OE(IO_PIN_FIRST_OE),
		.IO_PIN_SECOND_O(IO_PIN_SECOND_O), .IO_PIN_SECOND_OE(IO_PIN_SECOND_OE),
		.SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE(SERIAL_OUT_OE), .LGO_ENABLE(LGO_ENABLE),
		.DAC_CODE(DAC_CODE), .COARSE_GAIN(COARSE_GAIN), .FINE_GAIN(FINE_GAIN),
		.OFFSET_ADJ(OFFSET_ADJ));

	dscd_host u_host (.SCLK(SCLK), .SYNC_N(SYNC_N), .SDIN(SDIN), .SERIAL_OUT(SERIAL_OUT),
		.SERIAL_OUT_OE(SERIAL_OUT_OE));

	// Xorshift source for data words.
	function automatic logic [15:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[15:0];
	endfunction : rnd

	// Compares and counts; reports a mismatch at once.
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	// Queues a note only when the outputs are expected to move.
	task automatic note(input logic [63:0] nv);
		if (nv !== cur)
			exp_q.push_back(nv);
		cur = nv;
	endtask : note

	// Sends a raw frame and leaves time for the take and the update.
	task automatic raw(input logic [23:0] w, input int n);
		u_host.xfer(w, n);
		repeat (20) @(negedge CLK);
	endtask : raw

	// Sends a write frame after noting its expected effect.
	task automatic frame(input logic [2:0] sel, input logic [2:0] chan, input logic [15:0] d);
		logic [63:0] nv;
		int c;
		nv = cur;
		for (c = 0; c < 2; c++) begin
			if (chan == dscd_pkg::CHAN_BOTH || chan == c[2:0]) begin
				case (sel)
					dscd_pkg::SEL_DATA: begin
						in_code[c] = d;
						if (!LOAD_STROBE_N)
							nv[32+16*c +: 16] = d;
					end
					dscd_pkg::SEL_COARSE: nv[28+2*c +: 2] = d[1:0];
					dscd_pkg::SEL_FINE: nv[16+6*c +: 6] = d[5:0];
					dscd_pkg::SEL_OFFSET: nv[8*c +: 8] = d[7:0];
					default: ;
				endcase
			end
		end
		if (sel == dscd_pkg::SEL_FUNC && chan == dscd_pkg::FN_CLEAR) begin
			nv[63:32] = {2{dscd_pkg::CLEAR_TWOS}};
			in_code = '{dscd_pkg::CLEAR_TWOS, dscd_pkg::CLEAR_TWOS};
		end
		if (sel == dscd_pkg::SEL_FUNC && chan == dscd_pkg::FN_LOAD)
			nv[63:32] = {in_code[1], in_code[0]};
		note(nv);
		raw({2'b00, sel, chan, d}, 24);
	endtask : frame

	// Moves the load strobe; a fall loads every pending input value.
	task automatic strobe(input logic lv);
		if (!lv && LOAD_STROBE_N)
			note({in_code[1], in_code[0], cur[31:0]});
		LOAD_STROBE_N = lv;
		repeat (20) @(negedge CLK);
	endtask : strobe

	// Ends a test: every noted change must have been seen.
	task automatic done(input string name);
		check(64'(exp_q.size()), 64'h0);
		$display("test %s done", name);
	endtask : done

	// Watcher: each output change is matched to the oldest note.
	always @(negedge CLK) begin
		if (!SYS_RST && obs !== last_seen) begin
			if (exp_q.size() == 0)
				check(obs, last_seen);
			else
				check(obs, exp_q.pop_front());
			last_seen = obs;
		end
	end

	// Hang guard.
	initial begin
		repeat (100000) @(posedge CLK);
		fails++;
		tally_and_finish();
	end

	// Main sequence.
	initial begin
		CODING_SELECT = rng[3];
		repeat (8) @(negedge CLK);
		SYS_RST = 1'b0;
		repeat (6) @(negedge CLK);
		check({LGO_ENABLE, IO_PIN_SECOND_OE, IO_PIN_FIRST_OE, SERIAL_OUT_OE}, 64'h0);
		check(obs, 64'h0);
		done("reset");
		strobe(1'b0);
		for (i = 0; i < 3; i++)
			frame(dscd_pkg::SEL_DATA, chans[i], rnd());
		strobe(1'b1);
		frame(dscd_pkg::SEL_DATA, dscd_pkg::CHAN_A, rnd());
		frame(dscd_pkg::SEL_DATA, dscd_pkg::CHAN_B, rnd());
		strobe(1'b0);
		strobe(1'b1);
		frame(dscd_pkg::SEL_DATA, dscd_pkg::CHAN_BOTH, rnd());
		frame(dscd_pkg::SEL_FUNC, dscd_pkg::FN_LOAD, rnd());
		done("data and load");
		for (s = 3; s < 6; s++)
			for (i = 0; i < 3; i++)
				frame(s[2:0], chans[i], rnd());
		done("gains");
		strobe(1'b0);
		frame(3'h1, dscd_pkg::CHAN_A, rnd());
		frame(3'h6, dscd_pkg::CHAN_B, rnd());
		frame(3'h7, dscd_pkg::CHAN_BOTH, rnd());
		frame(dscd_pkg::SEL_FUNC, 3'h2, rnd());
		frame(dscd_pkg::SEL_DATA, 3'h3, rnd());
		frame(dscd_pkg::SEL_FUNC, dscd_pkg::FN_NOP, rnd());
		raw({2'b01, dscd_pkg::SEL_DATA, dscd_pkg::CHAN_A, rnd()}, 24);
		raw({2'b00, dscd_pkg::SEL_DATA, dscd_pkg::CHAN_A, rnd()}, 23);
		raw({2'b00, dscd_pkg::SEL_DATA, dscd_pkg::CHAN_B, rnd()}, 25);
		done("refused");
		frame(dscd_pkg::SEL_FUNC, dscd_pkg::FN_CLEAR, rnd());
		CODING_SELECT = 1'b1;
		frame(dscd_pkg::SEL_DATA, dscd_pkg::CHAN_BOTH, rnd() | 16'h0001);
		note({dscd_pkg::CLEAR_BIN, dscd_pkg::CLEAR_BIN, cur[31:0]});
		in_code = '{dscd_pkg::CLEAR_BIN, dscd_pkg::CLEAR_BIN};
		ASYNC_WIPE_N = 1'b0;
		repeat (4) @(negedge CLK);
		ASYNC_WIPE_N = 1'b1;
		repeat (40) @(negedge CLK);
		done("clear");
		frame(dscd_pkg::SEL_FUNC, dscd_pkg::FN_CTRL, 16'h003F);
		check({LGO_ENABLE, IO_PIN_SECOND_OE, IO_PIN_SECOND_O, IO_PIN_FIRST_OE,
			IO_PIN_FIRST_O}, 64'h1F);
		raw({2'b10, dscd_pkg::SEL_DATA, dscd_pkg::CHAN_A, 16'h0000}, 24);
		raw(24'h000000, 24);
		check(64'(u_host.oe_seen), 64'h0);
		frame(dscd_pkg::SEL_FUNC, dscd_pkg::FN_CTRL, 16'h0020);
		check({LGO_ENABLE, IO_PIN_SECOND_OE, IO_PIN_FIRST_OE}, 64'h4);
		ext_first = 1'b1;
		raw({2'b10, dscd_pkg::SEL_FUNC, dscd_pkg::FN_CTRL, 16'h0000}, 24);
		raw(24'h000000, 24);
		check(64'(u_host.rb_word[5:0]), 64'h22);
		check(64'(u_host.oe_seen), 64'h1);
		v = rnd();
		frame(dscd_pkg::SEL_DATA, dscd_pkg::CHAN_A, v);
		raw({2'b10, dscd_pkg::SEL_DATA, dscd_pkg::CHAN_A, 16'h0000}, 24);
		raw(24'h000000, 24);
		check(64'(u_host.rb_word[15:0]), 64'(v));
		done("control and readback");
		tally_and_finish();
	end
endmodule : dac_serial_command_decoder_tb
